// [shared/gpm_pkg.sv]
// Constants, carrier types and pin role table for the port mux register block
// Overview of operation
// - Eight two-bit function fields select pin roles
// - Pin 7 bits 15:14: gpio, trig3, sync7, irq1
// - Pin 6 bits 13:12: gpio, trig2, sync6, irq0
// - Pin 5 bits 11:10: gpio, trig1, sync5, clock
// - Pin 4 bits 9:8: gpio, trig0, sync4, irq1
// - Pin 3 bits 7:6: gpio, trig3, sync3, irq0
// - Pin 2 bits 5:4: por, trig2, sync2, clock
// - Pin 1 bits 3:2: gpio, trig1, sync1, sleep
// - Pin 0 bits 1:0: irq0, trig0, sync0, gpio
// - Function register at 0x00, resets to zero
// - Output enable at 0x04, resets all disabled
// - Pull enable at 0x08, resets disabled
// - Input enable at 0x0c gates input register
// - Read-only sampled input register at 0x10
// - Output data at 0x14 drives enabled gpio pins
// - Set register at 0x18 sets written ones
// - Clear register at 0x1c clears written ones
// - Invert register at 0x20 toggles written ones
// - Bits written zero to 0x18-0x20 leave output data unchanged
package gpm_pkg;

	localparam int          PINS      = 8;
	localparam int          FUNC_W    = 2;
	localparam int          SEQS      = 4;

	localparam logic [31:0] OFS_FUNC  = 32'h0000_0000;
	localparam logic [31:0] OFS_OEN   = 32'h0000_0004;
	localparam logic [31:0] OFS_PULL  = 32'h0000_0008;
	localparam logic [31:0] OFS_IEN   = 32'h0000_000c;
	localparam logic [31:0] OFS_DIN   = 32'h0000_0010;
	localparam logic [31:0] OFS_DOUT  = 32'h0000_0014;
	localparam logic [31:0] OFS_SET   = 32'h0000_0018;
	localparam logic [31:0] OFS_CLR   = 32'h0000_001c;
	localparam logic [31:0] OFS_TGL   = 32'h0000_0020;

	localparam logic [15:0] RST_FUNC  = 16'h0000;
	localparam logic [7:0]  RST_PORT  = 8'h00;

	localparam logic [1:0]  CODE_00   = 2'h0;
	localparam logic [1:0]  CODE_01   = 2'h1;
	localparam logic [1:0]  CODE_10   = 2'h2;
	localparam logic [1:0]  CODE_11   = 2'h3;

	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;

	typedef enum {
		GPM_ROLE_GPIO,
		GPM_ROLE_TRIG,
		GPM_ROLE_SYNC,
		GPM_ROLE_IRQ0,
		GPM_ROLE_IRQ1,
		GPM_ROLE_CLK,
		GPM_ROLE_POR,
		GPM_ROLE_SLEEP
	} gpm_role_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} gpm_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} gpm_ahb_rsp_t;

	typedef struct packed {
		logic [PINS-1:0] out;
		logic [PINS-1:0] oe_b;
	} gpm_pad_t;

	// Functions a pin can receive from the rest of the device
	typedef struct packed {
		logic [PINS-1:0] sync_dev;
		logic [1:0]      irq;
		logic            por;
		logic            sleep;
	} gpm_func_in_t;

	typedef struct packed {
		logic [SEQS-1:0] seq_trig;
		logic            ext_clk;
	} gpm_func_out_t;

	typedef struct packed {
		logic [15:0]     func;
		logic [PINS-1:0] oen;
		logic [PINS-1:0] pull;
		logic [PINS-1:0] ien;
		logic [PINS-1:0] din;
		logic [PINS-1:0] dout;
		logic [PINS-1:0] sync1;
		logic [PINS-1:0] sync2;
		logic            ph_valid;
		logic            ph_write;
		logic [31:0]     ph_addr;
		logic [31:0]     rdata;
		logic [PINS-1:0] pad_out;
		logic [PINS-1:0] pad_oe_b;
		logic [SEQS-1:0] trig;
		logic            ext_clk;
	} gpm_state_t;

	// Role table: each pin has its own meaning for the four codes
	function automatic gpm_role_t gpm_role(input int pin, input logic [1:0] code);
		gpm_role_t r;
		r = GPM_ROLE_GPIO;
		unique case (code)
			CODE_01: r = GPM_ROLE_TRIG;
			CODE_10: r = GPM_ROLE_SYNC;
			CODE_00: begin
				if (pin == 0)
					r = GPM_ROLE_IRQ0;
				else if (pin == 2)
					r = GPM_ROLE_POR;
				else
					r = GPM_ROLE_GPIO;
			end
			CODE_11: begin
				unique case (pin)
					0:       r = GPM_ROLE_GPIO;
					1:       r = GPM_ROLE_SLEEP;
					2:       r = GPM_ROLE_CLK;
					3:       r = GPM_ROLE_IRQ0;
					4:       r = GPM_ROLE_IRQ1;
					5:       r = GPM_ROLE_CLK;
					6:       r = GPM_ROLE_IRQ0;
					default: r = GPM_ROLE_IRQ1;
				endcase
			end
		endcase
		return r;
	endfunction

endpackage

// [rtl/gpm_port_mux_regs.sv]
// Eight-pin port function multiplexer with its AHB-Lite register bank
`timescale 1ns/1ps
module gpm_port_mux_regs (
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire gpm_pkg::gpm_ahb_req_t  ahb_req,
	output      gpm_pkg::gpm_ahb_rsp_t  ahb_rsp,
	input  wire logic [7:0]             pad_in,
	output      gpm_pkg::gpm_pad_t      pad,
	output      logic [7:0]             port_pull_enable,
	input  wire gpm_pkg::gpm_func_in_t  func_in,
	output      gpm_pkg::gpm_func_out_t func_out
);

	gpm_pkg::gpm_state_t s_q;
	gpm_pkg::gpm_state_t s_d;

	function automatic logic [31:0] read_mux(input gpm_pkg::gpm_state_t s,
		input logic [31:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (addr)
			gpm_pkg::OFS_FUNC: v = {16'h0000, s.func};
			gpm_pkg::OFS_OEN:  v = {24'h00_0000, s.oen};
			gpm_pkg::OFS_PULL: v = {24'h00_0000, s.pull};
			gpm_pkg::OFS_IEN:  v = {24'h00_0000, s.ien};
			gpm_pkg::OFS_DIN:  v = {24'h00_0000, s.din};
			gpm_pkg::OFS_DOUT: v = {24'h00_0000, s.dout};
			// Write-only and unmapped words read as zero
			default:           v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	always_comb begin
		logic            take;
		logic [7:0]      wd;
		logic [1:0]      code;
		gpm_pkg::gpm_role_t role;
		logic            drive;
		logic            lvl;
		take  = 1'b0;
		wd    = 8'h00;
		code  = 2'h0;
		role  = gpm_pkg::GPM_ROLE_GPIO;
		drive = 1'b0;
		lvl   = 1'b0;
		s_d   = s_q;

		// Two-stage synchroniser on the pads; only stage two is looked at
		s_d.sync1 = pad_in;
		s_d.sync2 = s_q.sync1;

		for (int i = 0; i < gpm_pkg::PINS; i++) begin
			s_d.din[i] = s_q.ien[i] & s_q.sync2[i];
		end

		// Data phase of a write: hwdata is valid now
		wd = s_q.ph_valid ? ahb_req.hwdata[7:0] : 8'h00;
		if (s_q.ph_valid && s_q.ph_write) begin
			unique case (s_q.ph_addr)
				gpm_pkg::OFS_FUNC: s_d.func = ahb_req.hwdata[15:0];
				gpm_pkg::OFS_OEN:  s_d.oen  = wd;
				gpm_pkg::OFS_PULL: s_d.pull = wd;
				gpm_pkg::OFS_IEN:  s_d.ien  = wd;
				gpm_pkg::OFS_DOUT: s_d.dout = wd;
				gpm_pkg::OFS_SET:  s_d.dout = s_q.dout | wd;
				gpm_pkg::OFS_CLR:  s_d.dout = s_q.dout & ~wd;
				gpm_pkg::OFS_TGL:  s_d.dout = s_q.dout ^ wd;
				// Input register and unmapped words ignore writes
				default: s_d.dout = s_q.dout;
			endcase
		end

		// Address phase; the slave never inserts wait states
		take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
		s_d.ph_valid = take;
		s_d.ph_write = take & ahb_req.hwrite;
		s_d.ph_addr  = take ? ahb_req.haddr : 32'h0000_0000;
		// Read from the updated copy so a read right after a write sees it
		if (take && !ahb_req.hwrite) begin
			s_d.rdata = read_mux(s_d, ahb_req.haddr);
		end

		// Pin multiplexer
		s_d.trig    = '0;
		s_d.ext_clk = 1'b0;
		for (int i = 0; i < gpm_pkg::PINS; i++) begin
			code  = s_q.func[i*gpm_pkg::FUNC_W +: gpm_pkg::FUNC_W];
			role  = gpm_pkg::gpm_role(i, code);
			drive = 1'b0;
			lvl   = 1'b0;
			unique case (role)
				gpm_pkg::GPM_ROLE_GPIO: begin
					drive = 1'b1;
					lvl   = s_q.dout[i];
				end
				gpm_pkg::GPM_ROLE_SYNC: begin
					drive = 1'b1;
					lvl   = func_in.sync_dev[i];
				end
				gpm_pkg::GPM_ROLE_IRQ0: begin
					drive = 1'b1;
					lvl   = func_in.irq[0];
				end
				gpm_pkg::GPM_ROLE_IRQ1: begin
					drive = 1'b1;
					lvl   = func_in.irq[1];
				end
				gpm_pkg::GPM_ROLE_POR: begin
					drive = 1'b1;
					lvl   = func_in.por;
				end
				gpm_pkg::GPM_ROLE_SLEEP: begin
					drive = 1'b1;
					lvl   = func_in.sleep;
				end
				gpm_pkg::GPM_ROLE_TRIG: begin
					s_d.trig[i % gpm_pkg::SEQS] = s_d.trig[i % gpm_pkg::SEQS] | s_q.sync2[i];
				end
				gpm_pkg::GPM_ROLE_CLK: begin
					// Sampled clock: only usable well below half of mclk
					s_d.ext_clk = s_d.ext_clk | s_q.sync2[i];
				end
			endcase
			// Every output role still needs its enable bit, input roles never drive
			s_d.pad_out[i]  = drive & s_q.oen[i] & lvl;
			s_d.pad_oe_b[i] = ~(drive & s_q.oen[i]);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q          <= '0;
			s_q.func     <= gpm_pkg::RST_FUNC;
			s_q.oen      <= gpm_pkg::RST_PORT;
			s_q.pull     <= gpm_pkg::RST_PORT;
			s_q.ien      <= gpm_pkg::RST_PORT;
			s_q.din      <= gpm_pkg::RST_PORT;
			s_q.dout     <= gpm_pkg::RST_PORT;
			s_q.pad_oe_b <= 8'hff;
		end else begin
			s_q <= s_d;
		end
	end

	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp     = gpm_pkg::HRESP_OKAY;
	assign ahb_rsp.hrdata    = s_q.rdata;
	assign pad.out           = s_q.pad_out;
	assign pad.oe_b          = s_q.pad_oe_b;
	assign port_pull_enable  = s_q.pull;
	assign func_out.seq_trig = s_q.trig;
	assign func_out.ext_clk  = s_q.ext_clk;

endmodule // gpm_port_mux_regs

// [tb/gpm_pin_model.sv]
// Far side of the port: host drivers, pull-ups and floating pins
`timescale 1ns/1ps
module gpm_pin_model (
	input  wire logic              mclk,
	input  wire gpm_pkg::gpm_pad_t pad,
	input  wire logic [7:0]        pull,
	input  wire logic [7:0]        ext_en,
	input  wire logic [7:0]        ext_val,
	output      logic [7:0]        pad_in
);
	logic flt_q = 1'h0;
	// A bare pin wanders each cycle so no stale level can be read back
	always @(posedge mclk) flt_q <= !flt_q;
	always_comb for (int i = 0; i < 8; i++)
		pad_in[i] = !pad.oe_b[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : pull[i] | flt_q;
endmodule // gpm_pin_model

// [tb/gpm_port_mux_regs_properties.sv]
// Bus and pin checks for the port mux register block
`timescale 1ns/1ps
module gpm_props (
	input wire logic                   mclk,
	input wire logic                   rst_b,
	input wire gpm_pkg::gpm_ahb_req_t  ahb_req,
	input wire gpm_pkg::gpm_ahb_rsp_t  ahb_rsp,
	input wire logic [7:0]             pad_in,
	input wire gpm_pkg::gpm_pad_t      pad,
	input wire logic [7:0]             port_pull_enable,
	input wire gpm_pkg::gpm_func_in_t  func_in,
	input wire gpm_pkg::gpm_func_out_t func_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wire logic        go = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
	wire logic        rd = go && !ahb_req.hwrite;
	wire logic        wr = go && ahb_req.hwrite;
	wire logic [31:0] a  = ahb_req.haddr;
	AST_OKAY: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
		else $error("bus stall");
	AST_RESET: assert property ($rose(rst_b) |->
		pad.oe_b == 8'hff && func_out == '0) else $error("reset outputs");
	AST_PULL: assert property (wr && a == 32'h8 |=> ##1
		port_pull_enable == $past(ahb_req.hwdata[7:0])) else $error("pull");
	AST_OEN: assert property (wr && a == 32'h4 ##1 ahb_req.hwdata[7:0] == 8'h0 |=> ##1
		pad.oe_b == 8'hff) else $error("drive off");
	// Triggers are synchronised, so any high one needs a high pin three edges back
	AST_TRIG: assert property ((func_out.seq_trig &
		~($past(pad_in[3:0], 3) | $past(pad_in[7:4], 3))) == 4'h0) else $error("trigger");
	AST_CLK: assert property (func_out.ext_clk |->
		$past(pad_in[2], 3) || $past(pad_in[5], 3)) else $error("clock");
	AST_WO: assert property (rd && a inside {32'h18, 32'h1c, 32'h20} |=>
		ahb_rsp.hrdata == 32'h0) else $error("write-only read");
	AST_NARROW: assert property (rd && a != 32'h0 |=>
		ahb_rsp.hrdata[31:8] == 24'h0) else $error("port width");
	cover property (rd && a == 32'h10);
	cover property (func_out.seq_trig != 4'h0);
	cover property (wr && a == 32'h8);
endmodule // gpm_props
bind gpm_port_mux_regs gpm_props u_props (.mclk(mclk), .rst_b(rst_b), .ahb_req(ahb_req),
	.ahb_rsp(ahb_rsp), .pad_in(pad_in), .pad(pad), .port_pull_enable(port_pull_enable),
	.func_in(func_in), .func_out(func_out));

// [tb/gpm_port_mux_regs_test.sv]
// Self-checking bench for the port mux register block
`timescale 1ns/1ps
module gpm_port_mux_regs_test;
	typedef struct {logic [15:0] wa, wd, ra, ex;} gpm_row_t;
	logic                   mclk = 1'h0, rst_b = 1'h0;
	gpm_pkg::gpm_ahb_req_t  req = '0, bus;
	gpm_pkg::gpm_ahb_rsp_t  rsp;
	gpm_pkg::gpm_pad_t      pad;
	gpm_pkg::gpm_func_in_t  fin = 12'h004;
	gpm_pkg::gpm_func_out_t fo;
	logic [7:0]             pin, pull, xen = 8'h24, xv = 8'h24;
	logic [31:0]            rd;
	int                     errors = 0, checks = 0, cyc = 0;
	// Drivers are switched on and then off again so the drive-off check sees a real change
	gpm_row_t rows[11] = '{'{16'h0, 16'hffff, 16'h0, 16'hffff}, '{16'h4, 16'h1ff, 16'h4, 16'hff},
		'{16'h4, 16'h0, 16'h4, 16'h0}, '{16'h8, 16'h1ff, 16'h8, 16'hff},
		'{16'hc, 16'hff, 16'hc, 16'hff}, '{16'h14, 16'h5a, 16'h14, 16'h5a},
		'{16'h18, 16'h81, 16'h14, 16'hdb}, '{16'h1c, 16'h42, 16'h14, 16'h99},
		'{16'h20, 16'hf, 16'h20, 16'h0}, '{16'h24, 16'hff, 16'h24, 16'h0},
		'{16'h4, 16'hff, 16'h4, 16'hff}};
	always_comb begin
		bus = req;
		bus.hready = rsp.hreadyout;
	end
	gpm_port_mux_regs dut (.mclk(mclk), .rst_b(rst_b), .ahb_req(bus), .ahb_rsp(rsp), .pad_in(pin),
		.pad(pad), .port_pull_enable(pull), .func_in(fin), .func_out(fo));
	gpm_pin_model ext (.mclk(mclk), .pad(pad), .pull(pull), .ext_en(xen), .ext_val(xv), .pad_in(pin));
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(logic w, logic [31:0] a, d);
		req.hsel <= 1'h1;
		req.hsize <= 3'h2;
		req.haddr <= a;
		req.hwrite <= w;
		req.htrans <= gpm_pkg::HTRANS_NONSEQ;
		do @(posedge mclk); while (rsp.hreadyout !== 1'h1);
		req.htrans <= 2'h0;
		req.hwdata <= d;
		do @(posedge mclk); while (rsp.hreadyout !== 1'h1);
		rd = rsp.hrdata;
	endtask
	// Pins settle through one register stage plus a two-flop synchroniser
	task automatic wset(logic [31:0] f);
		xfer(1'h1, 32'h0, f);
		repeat (5) @(posedge mclk);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			xfer(1'h0, 32'(i * 4), 32'h0);
			chk("reset", rd, 32'h0);
		end
		foreach (rows[i]) begin
			xfer(1'h1, 32'(rows[i].wa), 32'(rows[i].wd));
			xfer(1'h0, 32'(rows[i].ra), 32'h0);
			chk("readback", rd, 32'(rows[i].ex));
		end
		wset(32'hffff);
		chk("oe", 32'(pad.oe_b), 32'h24);
		chk("out", 32'(pad.out & 8'hdb), 32'h48);
		chk("clk", 32'(fo.ext_clk), 32'h1);
		xfer(1'h0, 32'h10, 32'h0);
		chk("din", rd, 32'h6c);
		xen <= 8'h00;
		fin <= 12'h005;
		wset(32'h0);
		chk("out0", 32'(pad.out), 32'h93);
		fin <= 12'h3c7;
		wset(32'haaaa);
		chk("sync", 32'(pad.out), 32'h3c);
		xen <= 8'hff;
		xv <= 8'h12;
		wset(32'h5555);
		chk("oe5", 32'(pad.oe_b), 32'hff);
		chk("trig", 32'(fo.seq_trig), 32'h3);
		// Reset again in mid-run: drivers, pulls and registers must fall back to idle
		rst_b <= 1'h0;
		@(posedge mclk);
		chk("rst oe", 32'(pad.oe_b), 32'hff);
		chk("rst pull", 32'(pull), 32'h0);
		chk("rst trig", 32'(fo.seq_trig), 32'h0);
		repeat (2) @(posedge mclk);
		rst_b <= 1'h1;
		xfer(1'h0, 32'h0, 32'h0);
		chk("rst func", rd, 32'h0);
		xfer(1'h0, 32'h14, 32'h0);
		chk("rst dout", rd, 32'h0);
		end_sim();
	end
endmodule // gpm_port_mux_regs_test
